// ===== verilog/eeprom_page_pkg.sv
// Constants, register map and types for the EEPROM page access logic.
// Assumes a 250 MHz APB clock; all offsets are 32-bit word aligned.
package eeprom_page_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] LOCATION_IDX = 6'h01;
    localparam logic [5:0] CONTROL_IDX = 6'h02;
    localparam logic [5:0] WINDOW_IDX = 6'h03;

    // Control register field positions
    localparam int CTL_IRQ_EN_BIT = 6;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_MC3_BIT = 3;
    localparam int CTL_MC2_BIT = 2;
    localparam int CTL_MC1_BIT = 1;

    // Location pointer fields
    localparam int PAGE_MSB = 6;
    localparam int PAGE_LSB = 2;
    localparam logic [7:0] LOCATION_WMASK = 8'h7f;

    // Reset values
    localparam logic [7:0] LOCATION_RST = 8'h00;
    localparam logic [2:0] MODE_BITS_RST = 3'h0;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'h00;

    // Timing: one erase or write phase
    localparam int unsigned PHASE_TIME_US = 5000;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned PHASE_CYCLES = PHASE_TIME_US * CLK_MHZ;

    localparam int ARRAY_BYTES = 128;
    localparam int PAGE_BYTES = 4;

    typedef enum logic [2:0] {
        MODE_READ = 3'h0,
        MODE_INCR = 3'h1,
        MODE_WRITE = 3'h2,
        MODE_ERASE_WRITE = 3'h3,
        MODE_ERASE = 3'h4,
        MODE_OTHER = 3'h5
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b11
    } state_t;

    function automatic mode_t mode_of(input logic busy, input logic [2:0] mc);
        mode_t m;
        m = MODE_OTHER;
        if (!busy) begin
            if (mc == 3'h0) m = MODE_READ;
            else if (mc == 3'h2) m = MODE_INCR;
        end else begin
            if (mc[2:1] == 2'h1) m = MODE_WRITE;
            else if (mc == 3'h4) m = MODE_ERASE_WRITE;
            else if (mc == 3'h7) m = MODE_ERASE;
        end
        return m;
    endfunction : mode_of

endpackage : eeprom_page_pkg

// ===== verilog/eeprom_page_access_logic.sv
// EEPROM page access logic: location pointer, data window, write latches,
// byte-select flags and timed erase/write page cycles behind an APB slave.
// Assumes one clock domain and synchronous APB master signals.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

// Register map, byte addresses on the APB side:
//   0x04 location pointer, 0x08 control, 0x0c data window.
//   Any other or unaligned address answers with pslverr and reads zero.
//   Only the low byte of each word carries data; the rest reads zero.
//
// Control register bits:
//   6 countdown irq enable, 4 cycle in progress, 3..1 mode control.
//   All other bits read zero and ignore writes.
//   While a cycle runs, a control write may only change the irq enable,
//   so a stray write from an interrupt handler cannot restart the cycle.
//
// Operation selected by busy and the mode bits:
//   busy 0, mode 000: read byte through the data window.
//   busy 0, mode 010: increment mode for page setup.
//   busy 1, mode 01x: write page.
//   busy 1, mode 100: erase then write page.
//   busy 1, mode 111: erase page.
//   A control write with busy 1 and any other mode stores the mode bits
//   but starts nothing; busy then reads back as zero.
//
// Location pointer:
//   Bit 7 is tied low; bits 6..2 name the page and 1..0 the byte or latch.
//   A data window read while not busy bumps the whole pointer, so reads can stream across
//   page boundaries; the count wraps from 0x7f to zero.
//   In increment mode a latch load steps only the two low bits and
//   saturates at latch 3, leaving the page bits alone.
//
// Write latches and byte-select flags:
//   Four latches, one per byte of a page, are set-only: a repeat load ORs.
//   Loading a latch raises its flag; only flagged bytes are touched.
//   Both are cleared in the cycle that drops busy, ready for the next setup.
//   A latch load landing on that same edge wins over the clear, so a late
//   load is kept rather than silently dropped.
//
// Cycle timing:
//   A phase lasts PHASE_CYCLES_P clocks from the control write's last edge.
//   Erase and write each take one phase, erase then write takes two.
//   The down-counter reloads itself between the erase and write phases.
//   The page bits are used again at each phase end, so software must
//   leave the pointer alone until busy has cleared.
//   At the end busy clears, the pointer steps unless the cycle was an
//   erase, and countdown_irq pulses for one clock if both enables are set.
//
// Limitations:
//   The array has no reset and starts unknown in simulation; erased bytes
//   read 0x00 and writes OR ones in.
//   The phase length is a fixed parameter; no reload register is modelled.
//   A page cycle with no flags set still runs for its full time.
//   Data window loads during a cycle are accepted but defeat the cycle's
//   intent; software is expected to poll busy before any new access.
//   The factory check register has no address here and answers pslverr.
//
// APB timing:
//   Every transfer takes one wait state; pready and pslverr are registered
//   and stand for one clock, and prdata holds until the next answer.
//   Side effects land on the edge at which pready is sampled high.

// How it works
// - Pointer increments after read and write cycles, not after erase cycles.
// - Pointer increment past its top value wraps to zero.
// - Pointer top bit stays zero; bits 6..2 pick one of 32 pages.
// - Page cycles ignore the low two pointer bits and use the page bits.
// - Reads use the low two bits as byte position within the page.
// - Page setup picks one of four latches by the low two bits only.
// - Increment mode advances the latch subcounter after each latch write.
// - The subcounter stops and holds at latch 3.
// - Data window read returns the array byte at the pointer; no storage.
// - Data window write loads the selected latch, not the array.
// - Latches are unreadable and a repeat write ORs into them.
// - All latches clear when any cycle completes, except one loaded on that same edge.
// - A latch load sets its byte-select flag; flags are hidden.
// - All flags clear when any cycle completes, except one set by a load on that same edge.
// - Cycle end clears busy and pulses the irq when both enables are set.
// - Read byte completes within the same register read.
// - Write and erase take 5 ms each; erase/write takes 10 ms.
// - Software sets busy to start; hardware clears it on completion.
// - Busy plus three mode bits select the operation; others are refused.
// - Bytes whose flag is zero are left unchanged by any page cycle.
// - Write ORs latches in; erase/write erases, re-times, then writes.
module eeprom_page_access_logic
    import eeprom_page_pkg::*;
#(
    parameter int unsigned PHASE_CYCLES_P = PHASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic derivative_irq_enable,
    output logic countdown_irq,
    output logic cycle_busy
);

    logic [7:0] array_mem [ARRAY_BYTES];

    logic [7:0] location_reg;
    logic [7:0] location_next;
    logic [2:0] mode_bits_reg;
    logic [2:0] mode_bits_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic busy_reg;
    logic busy_next;
    mode_t run_mode_reg;
    mode_t run_mode_next;
    state_t state_reg;
    state_t state_next;
    logic [31:0] timer_reg;
    logic [31:0] timer_next;
    logic [7:0] latch_reg [PAGE_BYTES];
    logic [7:0] latch_next [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] flag_reg;
    logic [PAGE_BYTES-1:0] flag_next;
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;
    logic irq_reg;
    logic irq_next;

    logic [PAGE_BYTES-1:0] arr_we;
    logic [7:0] arr_wd [PAGE_BYTES];

    logic accept;
    logic complete;
    logic phase_end;
    logic cycle_done;
    mode_t cur_mode;
    mode_t req_mode;
    logic [4:0] page;
    logic [1:0] sub;

    // Only word-aligned addresses decode; the low paddr bits must be zero
    function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
        return (a[7:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    // Bit 7 is masked so the count wraps from 0x7f straight to zero
    function automatic logic [7:0] wrap_inc(input logic [7:0] v);
        logic [7:0] s;
        s = v + 8'h01;
        return s & LOCATION_WMASK;
    endfunction : wrap_inc

    assign page = location_reg[PAGE_MSB:PAGE_LSB];
    assign sub = location_reg[1:0];
    assign accept = psel && penable && !pready;
    assign complete = psel && penable && pready;
    assign phase_end = (state_reg != ST_IDLE) && (timer_reg == 32'd1);
    assign cur_mode = mode_of(busy_reg, mode_bits_reg);
    assign req_mode = mode_of(pwdata[CTL_BUSY_BIT], pwdata[CTL_MC3_BIT:CTL_MC1_BIT]);

    // The sequencer owns the phase counter. It starts only from idle, on
    // the completing edge of a control write that names a page operation.
    // phase_end is raised in the last clock of a phase, when the counter
    // reads one, so the array update and the busy clear share one edge.
    // The register group below gates busy on the registered busy bit,
    // which moves together with the idle state, so the two never disagree
    // about whether a start was taken.
    //
    // Sequencer, timer and array update requests
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        cycle_done = 1'b0;
        arr_we = '0;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            arr_wd[i] = ERASED_BYTE;
        end
        if (state_reg != ST_IDLE) begin
            timer_next = timer_reg - 32'd1;
        end
        if (phase_end) begin
            unique case (state_reg)
                ST_ERASE: begin
                    arr_we = flag_reg;
                    if (run_mode_reg == MODE_ERASE_WRITE) begin
                        state_next = ST_WRITE;
                        timer_next = 32'(PHASE_CYCLES_P);
                    end else begin
                        state_next = ST_IDLE;
                        cycle_done = 1'b1;
                    end
                end
                ST_WRITE: begin
                    arr_we = flag_reg;
                    for (int i = 0; i < PAGE_BYTES; i++) begin
                        // After the erase phase the OR is a plain copy
                        if (run_mode_reg == MODE_ERASE_WRITE) begin
                            arr_wd[i] = latch_reg[i];
                        end else begin
                            arr_wd[i] = array_mem[{page, 2'(i)}] | latch_reg[i];
                        end
                    end
                    state_next = ST_IDLE;
                    cycle_done = 1'b1;
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
        if (state_reg == ST_IDLE && complete && pwrite && hit(paddr, CONTROL_IDX)) begin
            unique case (req_mode)
                MODE_WRITE: begin
                    state_next = ST_WRITE;
                    timer_next = 32'(PHASE_CYCLES_P);
                end
                MODE_ERASE, MODE_ERASE_WRITE: begin
                    state_next = ST_ERASE;
                    timer_next = 32'(PHASE_CYCLES_P);
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // Writes go to the page named by the pointer at the phase end; the low
    // pointer bits play no part, so all four bytes are reachable at once.
    // Array holds no reset: it stands for non-volatile storage
    always_ff @(posedge pclk) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (arr_we[i]) begin
                array_mem[{page, 2'(i)}] <= arr_wd[i];
            end
        end
    end

    // Priority inside this group, lowest first: cycle completion, then the
    // bus answer, then register writes, then the read-side pointer bump.
    // Later assignments win, which is what lets a latch load beat the clear.
    // The bus answer is computed in the first access clock and registered,
    // which gives the fixed single wait state.
    // A window read while busy still returns array data but leaves the
    // pointer alone, so the page of the running cycle cannot drift.
    //
    // Registers, latches, flags and bus answer
    always_comb begin
        location_next = location_reg;
        mode_bits_next = mode_bits_reg;
        irq_en_next = irq_en_reg;
        busy_next = busy_reg;
        run_mode_next = run_mode_reg;
        flag_next = flag_reg;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            latch_next[i] = latch_reg[i];
        end
        prdata_next = prdata;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        irq_next = 1'b0;

        if (cycle_done) begin
            busy_next = 1'b0;
            irq_next = irq_en_reg && derivative_irq_enable;
            flag_next = '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                latch_next[i] = LATCH_RST;
            end
            if (run_mode_reg != MODE_ERASE) begin
                location_next = wrap_inc(location_reg);
            end
        end

        if (accept) begin
            pready_next = 1'b1;
            prdata_next = 32'h0;
            if (hit(paddr, LOCATION_IDX)) begin
                prdata_next = {24'h0, location_reg};
            end else if (hit(paddr, CONTROL_IDX)) begin
                prdata_next[CTL_IRQ_EN_BIT] = irq_en_reg;
                prdata_next[CTL_BUSY_BIT] = busy_reg;
                prdata_next[CTL_MC3_BIT:CTL_MC1_BIT] = mode_bits_reg;
            end else if (hit(paddr, WINDOW_IDX)) begin
                if (!pwrite) begin
                    prdata_next = {24'h0, array_mem[location_reg[6:0]]};
                end
            end else begin
                pslverr_next = 1'b1;
            end
        end

        if (complete && pwrite) begin
            if (hit(paddr, LOCATION_IDX)) begin
                location_next = pwdata[7:0] & LOCATION_WMASK;
            end else if (hit(paddr, CONTROL_IDX)) begin
                irq_en_next = pwdata[CTL_IRQ_EN_BIT];
                // While a cycle runs only the irq enable may change
                if (!busy_reg) begin
                    mode_bits_next = pwdata[CTL_MC3_BIT:CTL_MC1_BIT];
                    if (req_mode == MODE_WRITE || req_mode == MODE_ERASE ||
                        req_mode == MODE_ERASE_WRITE) begin
                        busy_next = 1'b1;
                        run_mode_next = req_mode;
                    end
                end
            end else if (hit(paddr, WINDOW_IDX)) begin
                // Load after the clear so a late load is never lost
                latch_next[sub] = latch_reg[sub] | pwdata[7:0];
                flag_next[sub] = 1'b1;
                if (cur_mode == MODE_INCR && sub != 2'b11) begin
                    location_next = {location_reg[7:2], sub + 2'b01};
                end
            end
        end

        if (complete && !pwrite && hit(paddr, WINDOW_IDX) && !busy_reg) begin
            location_next = wrap_inc(location_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            location_reg <= LOCATION_RST;
            mode_bits_reg <= MODE_BITS_RST;
            irq_en_reg <= 1'b0;
            busy_reg <= 1'b0;
            run_mode_reg <= MODE_READ;
            flag_reg <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                latch_reg[i] <= LATCH_RST;
            end
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            location_reg <= location_next;
            mode_bits_reg <= mode_bits_next;
            irq_en_reg <= irq_en_next;
            busy_reg <= busy_next;
            run_mode_reg <= run_mode_next;
            flag_reg <= flag_next;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                latch_reg[i] <= latch_next[i];
            end
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // Both outputs come straight from flops to keep them glitch free
    assign countdown_irq = irq_reg;
    assign cycle_busy = busy_reg;

endmodule : eeprom_page_access_logic

// ===== dv/eeprom_page_access_logic_asserts.sv
// Checker for the EEPROM page access logic, bound to its top module.
// Assumes registered APB answers and a phase count set by parameter.
`timescale 1ns/1ps
module eeprom_page_checker #(
    parameter int unsigned PHASE_CYCLES_P = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic derivative_irq_enable,
    input wire logic countdown_irq,
    input wire logic cycle_busy
);
    int unsigned busy_cnt;
    logic rd_ack;
    // Counts sampled busy cycles so the phase length can be judged at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_cnt <= 0;
        else busy_cnt <= cycle_busy ? busy_cnt + 1 : 0;
    end
    assign rd_ack = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_read_quick: assert property (psel && penable && !pwrite |-> ##[0:1] pready)
        else $error("read not answered in time");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_top_zero: assert property (rd_ack && paddr == 8'h04 |-> prdata[7] == 1'b0)
        else $error("pointer top bit set");
    chk_upper_zero: assert property (rd_ack |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_phase_len: assert property ($fell(cycle_busy) |->
        busy_cnt == PHASE_CYCLES_P || busy_cnt == 2 * PHASE_CYCLES_P)
        else $error("cycle length wrong");
    chk_irq_at_end: assert property (countdown_irq |-> $fell(cycle_busy))
        else $error("irq outside cycle end");
    chk_irq_gated: assert property ($fell(cycle_busy) && !derivative_irq_enable
        && !$past(derivative_irq_enable) |-> !countdown_irq)
        else $error("irq not gated");
    chk_start_cause: assert property ($rose(cycle_busy) |->
        $past(psel && penable && pready && pwrite && paddr == 8'h08 && pwdata[4]))
        else $error("busy without start");
    chk_legal_mode: assert property ($rose(cycle_busy) |->
        $past(pwdata[3:1]) inside {3'b010, 3'b011, 3'b100, 3'b111})
        else $error("illegal mode started");
endmodule : eeprom_page_checker

bind eeprom_page_access_logic eeprom_page_checker #(.PHASE_CYCLES_P(PHASE_CYCLES_P)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .derivative_irq_enable(derivative_irq_enable), .countdown_irq(countdown_irq),
    .cycle_busy(cycle_busy));

// ===== dv/cpu_bus_model.sv
// CPU side model: issues APB transfers one at a time.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Serial transfers keep each access sequence whole
    // Any address is driven as given; the bench also probes the unmapped word 0x10
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show junk so stale values are never trusted
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : cpu_bus_model

// ===== dv/test_eeprom_page_access_logic.sv
// Self-checking bench for the EEPROM page access logic.
// Assumes the CPU bus model and a short phase count.
`timescale 1ns/1ps
module test_eeprom_page_access_logic
    import eeprom_page_pkg::*;
;
    localparam int unsigned PH = 8; // Short phase stands for the loaded interval
    localparam logic [7:0] PA = {LOCATION_IDX, 2'b00};
    localparam logic [7:0] CA = {CONTROL_IDX, 2'b00};
    localparam logic [7:0] WA = {WINDOW_IDX, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic die = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, busy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int arr[128];
    always #2 pclk = ~pclk;
    cpu_bus_model cpu_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    eeprom_page_access_logic #(.PHASE_CYCLES_P(PH)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .derivative_irq_enable(die),
        .countdown_irq(irq), .cycle_busy(busy));
    task summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task wr(input logic [7:0] a, input logic [7:0] d);
        cpu_u.xfer(1'b1, a, {24'h0, d}, r, e);
    endtask : wr
    task rd(input logic [7:0] a);
        cpu_u.xfer(1'b0, a, 32'h0, r, e);
    endtask : rd
    task page_op(input logic [7:0] ctl, input logic [4:0] pg, input logic [3:0] m);
        logic [7:0] d[4];
        logic ie;
        int n;
        ie = 1'($urandom);
        die <= 1'($urandom);
        for (int i = 0; i < 4; i++) d[i] = 8'($urandom);
        if (m == 4'hf) begin
            wr(CA, 8'h04);
            wr(PA, {1'b0, pg, 2'b00});
            for (int i = 0; i < 4; i++) wr(WA, d[i]);
            wr(WA, 8'h01);
            d[3] = d[3] | 8'h01;
            rd(PA);
            cmp(r, {25'h0, pg, 2'b11});
            wr(CA, 8'h00);
        end else begin
            for (int i = 0; i < 4; i++) if (m[i]) begin
                wr(PA, {1'b0, pg, 2'(i)});
                wr(WA, d[i]);
            end
        end
        wr(PA, {1'b0, pg, 2'b01});
        wr(CA, ctl | {1'b0, ie, 6'h0});
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 100);
        cmp(n, PH * (ctl == 8'h18 ? 2 : 1) + 1);
        cmp(irq, ie & die);
        for (int i = 0; i < 4; i++) if (m[i]) arr[{pg, 2'(i)}] = ctl == 8'h1e ? 0 :
            ctl == 8'h18 ? int'(d[i]) : arr[{pg, 2'(i)}] | d[i];
        rd(PA);
        cmp(r, {25'h0, pg, 2'b01} + (ctl == 8'h1e ? 0 : 1));
        wr(PA, {1'b0, pg, 2'b00});
        for (int i = 0; i < 4; i++) begin
            rd(WA);
            cmp(r, arr[{pg, 2'(i)}]);
        end
        rd(PA);
        cmp(r, ({pg, 2'b00} + 8'd4) & 8'h7f);
        $display("page op %h on page %0d done", ctl, pg);
    endtask : page_op
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h7876));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(PA);
        cmp(r, 32'h0);
        wr(PA, 8'hff);
        rd(PA);
        cmp(r, 32'h7f);
        rd(8'h10);
        cmp(e, 1'b1);
        $display("register test done");
        page_op(8'h18, 5'd5, 4'hf);
        page_op(8'h18, 5'd31, 4'hf);
        page_op(8'h14, 5'd5, 4'($urandom));
        page_op(8'h16, 5'd31, 4'($urandom));
        page_op(8'h1e, 5'd5, 4'($urandom));
        page_op(8'h18, 5'd31, 4'($urandom));
        summarize();
    end
endmodule : test_eeprom_page_access_logic
